// [common/video_adjust_defines.vh]
// register map, field layout, reset values and fixed codes for the video adjust stage
//
// Overview of operation
// R1 - U chroma multiplied by 8-bit gain, gain = factor x 128, factor 0 to 2.
// R2 - V chroma multiplied by its own 8-bit gain, same scaling as U.
// R3 - active-video subcarrier phase offset is 0.17578125 deg times (hue - 128).
// R4 - hue ff gives largest positive shift, 00 largest negative, about +/-22.5 deg.
// R5 - brightness adds signed offset in seven low register bits to scaled luma.
// R6 - offset spans -7.5..15 IRE (PAL, no pedestal) or 0..22.5 IRE (pedestal).
// R7 - host avoids brightness codes 3f to 44 inclusive; output may be invalid.
// R8 - sharpness low nibble picks luma response: 0 is -4 dB, 12 +4 dB, 6 normal.
// R9 - sharpness acts only when luma filter select is 100 and sharp enable set.
// R10 - host writes zeros to upper four sharpness bits, they are reserved.
// R11 - low nibble gain applies at block borders, high nibble gain inside block.
// R12 - noise mode: gain 0..1 step 1/8 on sub-threshold filter output, subtracted.
// R13 - sharpness mode: gain 0..0.5 step 1/16 on above-threshold output, added.
// R14 - data coring gain applies to luma inside the block, not at its border.
// R15 - threshold is six-bit magnitude 0..63 compared with filtered luma amplitude.
// R16 - border width bit: four pixel transition when one, two pixels when zero.
// R17 - block size bit: 16x16 pixel blocks when set, 8x8 when clear.
// R18 - noise mode bit: zero subtracts noise, one boosts sharpness.
// R19 - three-bit input select chooses the luma filter whose passband is processed.
// R20 - four-bit block offset shifts the block grid by 0..15 pixels.
// R21 - brightness field is two's complement, one code about 0.496 IRE.
// R22 - register changes take effect from the next pixel, without glitches.
`ifndef VIDEO_ADJUST_DEFINES_VH
`define VIDEO_ADJUST_DEFINES_VH

`define SUB_U_GAIN 6'h1e
`define SUB_V_GAIN 6'h1f
`define SUB_HUE 6'h20
`define SUB_BRIGHT 6'h21
`define SUB_SHARP 6'h22
`define SUB_NR_GAINS 6'h23
`define SUB_NR_THRESH 6'h24
`define SUB_NR_CTRL 6'h25
`define SUB_STATUS 6'h3e

`define RST_U_GAIN 8'h80
`define RST_V_GAIN 8'h80
`define RST_HUE 8'h80
`define RST_BRIGHT 8'h00
`define RST_SHARP 4'h6
`define RST_NR_GAINS 8'h00
`define RST_NR_THRESH 8'h00
`define RST_NR_CTRL 8'h00

`define HUE_CENTRE 9'h080
`define SHARP_NORMAL 5'h06
`define LUMA_SEL_EXTENDED 3'h4
`define GAIN_UNITY_SHIFT 7
`define NR_SUB_SHIFT 3
`define NR_ADD_SHIFT 4
`define BRIGHT_SHIFT 2

`define THR_LSB 0
`define BORDER_WIDTH_BIT 6
`define BLOCK_SIZE_BIT 7
`define NR_MODE_BIT 3
`define GRID_OFF_LSB 4

`endif

// [rtl/pixel_fifo.v]
// small flip-flop fifo with valid/ready on both sides
module pixel_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire ref_clk_i, // clock
  input wire resetn_i, // async reset, active low
  input wire in_valid_i, // write request
  output wire in_ready_o, // space available
  input wire [WIDTH-1:0] in_data_i, // write data
  output wire out_valid_o, // data available
  input wire out_ready_i, // read accept
  output wire [WIDTH-1:0] out_data_o, // read data
  output wire full_o, // no space
  output wire empty_o // no data
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;
  integer i;

  assign full_o = (cnt_q == DEPTH[AW:0]);
  assign empty_o = (cnt_q == {(AW+1){1'b0}});
  assign in_ready_o = ~full_o;
  assign out_valid_o = ~empty_o;
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i & ~full_o;
  assign pop = out_ready_i & ~empty_o;

  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_q[i] <= {WIDTH{1'b0}};
      end
    end else begin
      if (push) begin
        mem_q[wr_q] <= in_data_i;
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // pixel_fifo

// [rtl/video_color_dnr_control.v]
// colour gain, hue, brightness, sharpness and block noise reduction stage with serial registers
`include "video_adjust_defines.vh"
module video_color_dnr_control #(
  parameter [6:0] DEV_ADDR = 7'h2a, // arbitrary serial device address
  parameter FIFO_DEPTH = 4,
  parameter FIFO_AW = 2
) (
  input wire ref_clk_i, // 40 MHz clock
  input wire resetn_i, // async reset, active low
  input wire scl_i, // serial clock pin
  input wire sda_i, // serial data pin level
  output wire sda_o, // serial data drive level, always low
  output wire sda_oe_o, // serial data pulls low when high
  input wire [2:0] luma_filter_sel_i, // luma filter select from mode logic
  input wire sharp_filter_enable_i, // sharpness filter enable
  input wire active_video_i, // high during active video, low around burst
  input wire in_valid_i, // input pixel valid
  output wire in_ready_o, // input pixel accepted
  input wire in_sol_i, // first pixel of a line
  input wire in_sof_i, // first pixel of a frame
  input wire [9:0] in_y_i, // luma, unsigned
  input wire [9:0] in_u_i, // U, two's complement
  input wire [9:0] in_v_i, // V, two's complement
  output wire out_valid_o, // output pixel valid
  input wire out_ready_i, // output pixel taken
  output wire [9:0] out_y_o, // processed luma
  output wire [9:0] out_u_o, // scaled U
  output wire [9:0] out_v_o, // scaled V
  output wire out_border_o, // pixel was in a block border
  output wire [8:0] hue_phase_o // signed phase offset, 0.17578125 deg steps
);
  localparam ST_IDLE = 3'd0;
  localparam ST_DEV = 3'd1;
  localparam ST_ACK = 3'd2;
  localparam ST_SUB = 3'd3;
  localparam ST_WR = 3'd4;
  localparam ST_RD = 3'd5;
  localparam ST_RACK = 3'd6;

  // pin synchronisers, level changes only once stages two and three agree
  reg [2:0] scl_s_q;
  reg [2:0] sda_s_q;
  reg scl_f_q;
  reg sda_f_q;
  reg scl_p_q;
  reg sda_p_q;
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[1:0], scl_i};
      sda_s_q <= {sda_s_q[1:0], sda_i};
      if (scl_s_q[1] == scl_s_q[2]) begin
        scl_f_q <= scl_s_q[2];
      end
      if (sda_s_q[1] == sda_s_q[2]) begin
        sda_f_q <= sda_s_q[2];
      end
      scl_p_q <= scl_f_q;
      sda_p_q <= sda_f_q;
    end
  end
  wire scl_rise = scl_f_q & ~scl_p_q;
  wire scl_fall = ~scl_f_q & scl_p_q;
  wire start_det = scl_f_q & scl_p_q & sda_p_q & ~sda_f_q;
  wire stop_det = scl_f_q & scl_p_q & ~sda_p_q & sda_f_q;

  // register file
  reg [7:0] u_gain_q;
  reg [7:0] v_gain_q;
  reg [7:0] hue_phase_offset_q;
  reg [7:0] brightness_offset_q;
  reg [3:0] sharpness_select_q;
  reg [7:0] noise_coring_gains_q;
  reg [7:0] noise_threshold_block_q;
  reg [7:0] noise_control_q;
  reg last_border_q;
  wire fifo_full;
  wire fifo_empty;

  function [7:0] rd_mux;
    input [5:0] sub;
    begin
      case (sub)
        `SUB_U_GAIN: rd_mux = u_gain_q;
        `SUB_V_GAIN: rd_mux = v_gain_q;
        `SUB_HUE: rd_mux = hue_phase_offset_q;
        `SUB_BRIGHT: rd_mux = brightness_offset_q;
        `SUB_SHARP: rd_mux = {4'h0, sharpness_select_q};
        `SUB_NR_GAINS: rd_mux = noise_coring_gains_q;
        `SUB_NR_THRESH: rd_mux = noise_threshold_block_q;
        `SUB_NR_CTRL: rd_mux = noise_control_q;
        `SUB_STATUS: rd_mux = {5'h00, last_border_q, fifo_full, fifo_empty};
        default: rd_mux = 8'h00;
      endcase
    end
  endfunction

  // serial slave: device byte, sub-address, then write or read bytes with auto increment
  reg [2:0] st_q;
  reg [2:0] bit_q;
  reg [7:0] sh_q;
  reg [5:0] sub_q;
  reg rw_q;
  reg sub_done_q;
  reg oe_q;
  wire [7:0] byte_in = {sh_q[6:0], sda_f_q};
  wire [7:0] rd_byte = rd_mux(sub_q);
  assign sda_o = 1'b0;
  assign sda_oe_o = oe_q;

  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q <= ST_IDLE;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      sub_q <= 6'h00;
      rw_q <= 1'b0;
      sub_done_q <= 1'b0;
      oe_q <= 1'b0;
      u_gain_q <= `RST_U_GAIN;
      v_gain_q <= `RST_V_GAIN;
      hue_phase_offset_q <= `RST_HUE;
      brightness_offset_q <= `RST_BRIGHT;
      sharpness_select_q <= `RST_SHARP;
      noise_coring_gains_q <= `RST_NR_GAINS;
      noise_threshold_block_q <= `RST_NR_THRESH;
      noise_control_q <= `RST_NR_CTRL;
    end else if (stop_det) begin
      st_q <= ST_IDLE;
      oe_q <= 1'b0;
    end else if (start_det) begin
      st_q <= ST_DEV;
      bit_q <= 3'h0;
      sub_done_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      case (st_q)
        ST_DEV, ST_SUB, ST_WR: begin
          if (scl_rise) begin
            sh_q <= byte_in;
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              st_q <= ST_ACK;
              if (st_q == ST_DEV) begin
                rw_q <= byte_in[0];
                if (byte_in[7:1] != DEV_ADDR) begin
                  st_q <= ST_IDLE;
                end
              end else if (st_q == ST_SUB) begin
                sub_q <= byte_in[5:0];
                sub_done_q <= 1'b1;
              end else begin
                // new values land between pixels, so each pixel sees one setting [R22]
                case (sub_q)
                  `SUB_U_GAIN: u_gain_q <= byte_in; // [R1]
                  `SUB_V_GAIN: v_gain_q <= byte_in; // [R2]
                  `SUB_HUE: hue_phase_offset_q <= byte_in;
                  `SUB_BRIGHT: brightness_offset_q <= byte_in;
                  `SUB_SHARP: sharpness_select_q <= byte_in[3:0]; // upper bits held at zero [R10]
                  `SUB_NR_GAINS: noise_coring_gains_q <= byte_in;
                  `SUB_NR_THRESH: noise_threshold_block_q <= byte_in;
                  `SUB_NR_CTRL: noise_control_q <= byte_in;
                  default: ;
                endcase
                sub_q <= sub_q + 6'h01;
              end
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (!oe_q && bit_q == 3'h0) begin
              oe_q <= 1'b1;
            end else if (rw_q) begin
              sh_q <= rd_byte;
              oe_q <= ~rd_byte[7];
              sub_q <= sub_q + 6'h01;
              bit_q <= 3'h0;
              st_q <= ST_RD;
            end else begin
              oe_q <= 1'b0;
              bit_q <= 3'h0;
              st_q <= sub_done_q ? ST_WR : ST_SUB;
            end
          end
        end
        ST_RD: begin
          if (scl_rise) begin
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              st_q <= ST_RACK;
            end
          end else if (scl_fall) begin
            sh_q <= {sh_q[6:0], 1'b0};
            oe_q <= ~sh_q[6];
          end
        end
        ST_RACK: begin
          if (scl_fall && oe_q) begin
            oe_q <= 1'b0;
          end else if (scl_rise) begin
            // master ack continues the read, a nack ends it
            st_q <= sda_f_q ? ST_IDLE : ST_ACK;
            bit_q <= 3'h1;
          end
        end
        default: begin
          oe_q <= 1'b0;
        end
      endcase
    end
  end
  // after a master ack, bit_q of one in ST_ACK loads the next byte on the coming fall

  // input buffering
  wire f_valid;
  wire f_ready;
  wire [31:0] f_data;
  pixel_fifo #(
    .WIDTH(32),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .in_valid_i(in_valid_i),
    .in_ready_o(in_ready_o),
    .in_data_i({in_sof_i, in_sol_i, in_y_i, in_u_i, in_v_i}),
    .out_valid_o(f_valid),
    .out_ready_i(f_ready),
    .out_data_o(f_data),
    .full_o(fifo_full),
    .empty_o(fifo_empty)
  );

  reg out_valid_q;
  assign f_ready = ~out_valid_q | out_ready_i;
  wire take = f_valid & f_ready;
  wire p_sof = f_data[31];
  wire p_sol = f_data[30];
  wire [9:0] p_y = f_data[29:20];
  wire signed [9:0] p_u = f_data[19:10];
  wire signed [9:0] p_v = f_data[9:0];

  // block grid position
  reg [10:0] col_q;
  reg [10:0] row_q;
  reg [9:0] y_p1_q;
  reg [9:0] y_p2_q;
  wire [10:0] col_now = p_sol ? 11'h000 : col_q;
  wire [10:0] row_now = p_sof ? 11'h000 : (p_sol ? row_q + 11'h001 : row_q);
  wire [3:0] grid_off = noise_control_q[`GRID_OFF_LSB +: 4];
  wire [10:0] col_sh = col_now - {7'h00, grid_off}; // [R20]
  wire big_blk = noise_threshold_block_q[`BLOCK_SIZE_BIT];
  wire [3:0] bmask = big_blk ? 4'hf : 4'h7; // [R17]
  // half the transition lies on each side of a block edge
  wire [3:0] bw = noise_threshold_block_q[`BORDER_WIDTH_BIT] ? 4'h2 : 4'h1; // [R16]
  wire [3:0] cpos = col_sh[3:0] & bmask;
  wire [3:0] rpos = row_now[3:0] & bmask;
  wire in_border = (cpos < bw) | (cpos > bmask - bw) | (rpos < bw) | (rpos > bmask - bw);

  function [9:0] clip_u10;
    input signed [15:0] v;
    begin
      if (v < 16'sd0) begin
        clip_u10 = 10'h000;
      end else if (v > 16'sd1023) begin
        clip_u10 = 10'h3ff;
      end else begin
        clip_u10 = v[9:0];
      end
    end
  endfunction

  function [9:0] chroma_scale;
    input signed [9:0] c;
    input [7:0] g;
    reg signed [18:0] prod;
    begin
      prod = c * $signed({1'b0, g});
      prod = prod >>> `GAIN_UNITY_SHIFT;
      if (prod > 19'sd511) begin
        chroma_scale = 10'h1ff;
      end else if (prod < -19'sd512) begin
        chroma_scale = 10'h200;
      end else begin
        chroma_scale = prod[9:0];
      end
    end
  endfunction

  // luma datapath
  reg signed [11:0] hp;
  reg [11:0] mag;
  reg [3:0] gain;
  reg signed [15:0] corr;
  reg signed [15:0] ysum;
  reg signed [4:0] sh_gain;
  always @* begin
    hp = 12'sd0;
    corr = 16'sd0;
    sh_gain = 5'sd0;
    // input filter choice sets the passband that is cored [R19]
    case (noise_control_q[2:0])
      3'h0: hp = $signed({2'b00, p_y}) - $signed({2'b00, y_p1_q});
      3'h1: hp = ($signed({2'b00, p_y}) - $signed({2'b00, y_p1_q})) >>> 1;
      3'h2: hp = ($signed({2'b00, p_y}) - $signed({2'b00, y_p2_q})) >>> 1;
      3'h3: hp = ($signed({2'b00, p_y}) - $signed({2'b00, y_p2_q})) >>> 2;
      default: hp = ($signed({1'b0, p_y, 1'b0}) - $signed({2'b00, y_p1_q})
                     - $signed({2'b00, y_p2_q})) >>> 2;
    endcase
    mag = hp[11] ? 12'd0 - hp : hp; // [R15]
    gain = in_border ? noise_coring_gains_q[3:0] : noise_coring_gains_q[7:4]; // [R11] [R14]
    if (noise_control_q[`NR_MODE_BIT]) begin // [R18]
      if (mag > {6'h00, noise_threshold_block_q[5:0]}) begin
        corr = (hp * $signed({1'b0, gain})) >>> `NR_ADD_SHIFT; // [R13]
      end
    end else begin
      if (mag < {6'h00, noise_threshold_block_q[5:0]}) begin
        corr = -((hp * $signed({1'b0, gain})) >>> `NR_SUB_SHIFT); // [R12]
      end
    end
    if (luma_filter_sel_i == `LUMA_SEL_EXTENDED && sharp_filter_enable_i) begin // [R9]
      // code 6 is flat, each step about 2/3 dB of high band lift or cut
      sh_gain = $signed({1'b0, sharpness_select_q}) - $signed(`SHARP_NORMAL); // [R8]
    end
    // brightness code is signed, four LSBs of the 10-bit scale per code [R21]
    ysum = $signed({6'h00, p_y}) + corr + ((hp * sh_gain) >>> 4)
           + ($signed({{9{brightness_offset_q[6]}}, brightness_offset_q[6:0]})
              <<< `BRIGHT_SHIFT); // [R5] [R6]
  end

  reg [9:0] y_q;
  reg [9:0] u_q;
  reg [9:0] v_q;
  reg border_q;
  reg [8:0] hue_q;
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      out_valid_q <= 1'b0;
      col_q <= 11'h000;
      row_q <= 11'h000;
      y_p1_q <= 10'h000;
      y_p2_q <= 10'h000;
      y_q <= 10'h000;
      u_q <= 10'h000;
      v_q <= 10'h000;
      border_q <= 1'b0;
      last_border_q <= 1'b0;
      hue_q <= 9'h000;
    end else begin
      // offset is zero outside active video so burst keeps reference phase [R3] [R4]
      hue_q <= active_video_i ? ({1'b0, hue_phase_offset_q} - `HUE_CENTRE) : 9'h000;
      if (take) begin
        out_valid_q <= 1'b1;
        col_q <= col_now + 11'h001;
        row_q <= row_now;
        y_p2_q <= p_sol ? p_y : y_p1_q;
        y_p1_q <= p_y;
        y_q <= clip_u10(ysum);
        u_q <= chroma_scale(p_u, u_gain_q); // [R1]
        v_q <= chroma_scale(p_v, v_gain_q); // [R2]
        border_q <= in_border;
        last_border_q <= in_border;
      end else if (out_ready_i) begin
        out_valid_q <= 1'b0;
      end
    end
  end

  assign out_valid_o = out_valid_q;
  assign out_y_o = y_q;
  assign out_u_o = u_q;
  assign out_v_o = v_q;
  assign out_border_o = border_q;
  assign hue_phase_o = hue_q;
endmodule // video_color_dnr_control

// [test/video_color_dnr_control_properties.sv]
// port assertions for the video adjust stage
module video_color_dnr_control_properties (
  input wire logic ref_clk_i, // clock
  input wire logic resetn_i, // async reset, active low
  input wire logic scl_i, // serial clock
  input wire logic sda_oe_o, // serial pull enable
  input wire logic active_video_i, // active video
  input wire logic in_valid_i, // input valid
  input wire logic in_ready_o, // input ready
  input wire logic out_valid_o, // output valid
  input wire logic out_ready_i, // output taken
  input wire logic [9:0] out_y_o, // luma
  input wire logic [9:0] out_u_o, // U
  input wire logic [9:0] out_v_o, // V
  input wire logic out_border_o, // border flag
  input wire logic [8:0] hue_phase_o // phase offset
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  property p_hue_blank;
    !active_video_i |=> hue_phase_o == 9'h000;
  endproperty
  a_hue_blank: assert property (p_hue_blank) else $error("hue offset outside video");
  property p_out_hold;
    out_valid_o && !out_ready_i |=> out_valid_o
      && $stable({out_y_o, out_u_o, out_v_o, out_border_o});
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("output moved while stalled");
  property p_first_out;
    in_valid_i && in_ready_o && !out_valid_o |-> ##2 out_valid_o;
  endproperty
  a_first_out: assert property (p_first_out) else $error("output late");
  property p_rose_cause;
    $rose(out_valid_o) |-> $past(in_valid_i, 2) && $past(in_ready_o, 2);
  endproperty
  a_rose_cause: assert property (p_rose_cause) else $error("output without input");
  property p_full_hold;
    !in_ready_o && !(out_valid_o && out_ready_i) |=> !in_ready_o;
  endproperty
  a_full_hold: assert property (p_full_hold) else $error("space from nowhere");
  property p_idle_stay;
    !out_valid_o && !in_valid_i && !$past(in_valid_i) |=> !out_valid_o;
  endproperty
  a_idle_stay: assert property (p_idle_stay) else $error("spurious output");
  property p_ready_idle;
    !out_valid_o |-> in_ready_o;
  endproperty
  a_ready_idle: assert property (p_ready_idle) else $error("refused while empty");
  property p_oe_scl_low;
    $changed(sda_oe_o) |-> !scl_i;
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("data pin moved, clock high");
endmodule // video_color_dnr_control_properties

bind video_color_dnr_control video_color_dnr_control_properties chk_u (
  .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .scl_i(scl_i), .sda_oe_o(sda_oe_o),
  .active_video_i(active_video_i), .in_valid_i(in_valid_i), .in_ready_o(in_ready_o),
  .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .out_y_o(out_y_o),
  .out_u_o(out_u_o), .out_v_o(out_v_o), .out_border_o(out_border_o),
  .hue_phase_o(hue_phase_o));

// [test/video_color_dnr_control_test.sv]
// self-checking bench for the video adjust stage
module video_color_dnr_control_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam [6:0] ADDR = 7'h2a;
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic scl_m = 1'b1;
  logic sda_m = 1'b1;
  logic [2:0] lsel = 3'h0;
  logic sh_en = 1'b0;
  logic act = 1'b0;
  logic out_rdy = 1'b1;
  logic sda_o, sda_oe, in_valid, in_ready, sol, sof, out_valid, border;
  logic [9:0] y, u, v, oy, ou, ov;
  logic [8:0] hue;
  int taken, base, p;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [30:0] outq[$];
  logic [30:0] o;
  logic [7:0] r;
  logic a;
  logic [7:0] hv[3] = '{8'h97, 8'h00, 8'hff};
  logic [8:0] he[3] = '{9'h017, 9'h180, 9'h07f};
  logic [7:0] nc[4] = '{8'h00, 8'h00, 8'h08, 8'h08};
  logic [7:0] nt[4] = '{8'h3f, 8'h0a, 8'h05, 8'h0a};
  logic [9:0] ne[4] = '{10'd500, 10'd510, 10'd515, 10'd510};
  logic [7:0] sc[4] = '{8'h00, 8'h0c, 8'h0c, 8'h0c};
  logic se[4] = '{1'b1, 1'b1, 1'b0, 1'b1};
  logic [2:0] sl[4] = '{3'h4, 3'h4, 3'h4, 3'h3};
  logic [9:0] sx[4] = '{10'd532, 10'd547, 10'd540, 10'd540};
  // open drain: anyone pulling low wins
  wire sda_w = sda_oe ? (sda_o & sda_m) : sda_m;

  video_color_dnr_control #(.DEV_ADDR(ADDR)) dut_u (.ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i), .scl_i(scl_m), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .luma_filter_sel_i(lsel), .sharp_filter_enable_i(sh_en), .active_video_i(act),
    .in_valid_i(in_valid), .in_ready_o(in_ready), .in_sol_i(sol), .in_sof_i(sof),
    .in_y_i(y), .in_u_i(u), .in_v_i(v), .out_valid_o(out_valid), .out_ready_i(out_rdy),
    .out_y_o(oy), .out_u_o(ou), .out_v_o(ov), .out_border_o(border), .hue_phase_o(hue));
  video_source src_u (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .ready_i(in_ready),
    .valid_o(in_valid), .sol_o(sol), .sof_o(sof), .y_o(y), .u_o(u), .v_o(v),
    .taken_o(taken));

  initial forever #12.5 ref_clk_i = ~ref_clk_i;

  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (out_valid && out_rdy)
      outq.push_back({border, oy, ou, ov});
    if (cycles == 60000) begin
      bad_count++;
      $display("MISMATCH run length expected finish seen hang");
      complete_run();
    end
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  // start is cond(1,0), stop is cond(0,1)
  task automatic cond(input logic s0, input logic s1);
    tick(2);
    sda_m <= s0;
    tick(10);
    scl_m <= 1'b1;
    tick(10);
    sda_m <= s1;
    tick(10);
    scl_m <= s1;
  endtask
  // data set up away from the clock fall so it never looks like start or stop
  task automatic bitx(input logic b, output logic s);
    tick(2);
    sda_m <= b;
    tick(10);
    scl_m <= 1'b1;
    tick(9);
    @(negedge ref_clk_i) s = sda_w;
    @(posedge ref_clk_i) scl_m <= 1'b0;
  endtask
  task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
    output logic ack);
    for (int i = 7; i >= 0; i--) bitx(tx[i], rx[i]);
    bitx(last, ack);
  endtask
  task automatic wr(input logic [5:0] sub, input logic [7:0] d);
    logic [7:0] x;
    logic k;
    cond(1'b1, 1'b0);
    xfer({ADDR, 1'b0}, 1'b1, x, k);
    chk("ack address", 1'b0, k);
    xfer({2'b00, sub}, 1'b1, x, k);
    chk("ack subaddress", 1'b0, k);
    xfer(d, 1'b1, x, k);
    chk("ack data", 1'b0, k);
    cond(1'b0, 1'b1);
  endtask
  task automatic rd(input logic [5:0] sub, output logic [7:0] d);
    logic k;
    cond(1'b1, 1'b0);
    xfer({ADDR, 1'b0}, 1'b1, d, k);
    xfer({2'b00, sub}, 1'b1, d, k);
    cond(1'b1, 1'b0);
    xfer({ADDR, 1'b1}, 1'b1, d, k);
    xfer(8'hff, 1'b1, d, k);
    cond(1'b0, 1'b1);
  endtask
  task automatic px(input logic l, input logic f, input logic [9:0] py);
    src_u.q.push_back({f, l, py, 10'h000, 10'h000});
  endtask
  task automatic take;
    for (int k = 0; k < 300 && outq.size() == 0; k++) tick(1);
    o = '1;
    if (outq.size() != 0)
      o = outq.pop_front();
    else
      chk("output present", 1, 0);
  endtask

  initial begin
    tick(5);
    resetn_i <= 1'b1;
    tick(6);
    rd(6'h1e, r);
    chk("u_gain", 8'h80, r);
    rd(6'h1f, r);
    chk("v_gain", 8'h80, r);
    rd(6'h20, r);
    chk("hue_phase_offset", 8'h80, r);
    rd(6'h22, r);
    chk("sharpness_select", 8'h06, r);
    wr(6'h22, 8'h0b);
    rd(6'h22, r);
    chk("sharpness_select", 8'h0b, r);
    rd(6'h10, r);
    chk("unmapped", 8'h00, r);
    rd(6'h3e, r);
    chk("status", 8'h01, r);
    cond(1'b1, 1'b0);
    xfer({7'h15, 1'b0}, 1'b1, r, a);
    cond(1'b0, 1'b1);
    chk("foreign address ack", 1'b1, a);
    $display("registers test done");
    wr(6'h1e, 8'h40);
    wr(6'h1f, 8'hff);
    src_u.q.push_back({2'b01, 10'd500, 10'd100, 10'h39c});
    take();
    chk("u out", 10'h032, o[19:10]);
    chk("v out", 10'h338, o[9:0]);
    for (int i = 0; i < 2; i++) begin
      wr(6'h21, i ? 8'h72 : 8'h1e);
      px(1'b1, 1'b0, 10'd500);
      take();
      chk("bright y", i ? 10'd444 : 10'd620, o[29:20]);
    end
    wr(6'h21, 8'h00);
    $display("chroma and brightness test done");
    act <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      wr(6'h20, hv[i]);
      tick(3);
      chk("hue phase", he[i], hue);
    end
    act <= 1'b0;
    tick(3);
    chk("hue blank", 9'h000, hue);
    $display("hue test done");
    wr(6'h23, 8'h88);
    for (int i = 0; i < 4; i++) begin
      wr(6'h25, nc[i]);
      wr(6'h24, nt[i]);
      px(1'b1, 1'b0, 10'd500);
      px(1'b0, 1'b0, 10'd510);
      take();
      take();
      chk("coring y", ne[i], o[29:20]);
    end
    $display("noise test done");
    wr(6'h23, 8'h00);
    wr(6'h24, 8'h00);
    wr(6'h25, 8'h04);
    for (int i = 0; i < 4; i++) begin
      wr(6'h22, sc[i]);
      sh_en <= se[i];
      lsel <= sl[i];
      px(1'b1, 1'b0, 10'd500);
      px(1'b0, 1'b0, 10'd500);
      px(1'b0, 1'b0, 10'd540);
      repeat (3) take();
      chk("sharp y", sx[i], o[29:20]);
    end
    $display("sharpness test done");
    for (int i = 0; i < 2; i++) begin
      wr(6'h24, i ? 8'hc0 : 8'h00);
      wr(6'h25, i ? 8'h30 : 8'h00);
      for (int j = 0; j < 48; j++) px(j % 16 == 0, j == 0, 10'd500);
      for (int j = 0; j < 48; j++) begin
        take();
        p = (j % 16 - (i ? 3 : 0) + 16) % (i ? 16 : 8);
        if (j >= 32)
          chk("border", p < (i ? 2 : 1) || p > (i ? 13 : 6), o[30]);
      end
    end
    $display("border test done");
    out_rdy <= 1'b0;
    base = taken;
    for (int j = 0; j < 8; j++) px(1'b0, 1'b0, 10'(j));
    tick(30);
    chk("accepted while stalled", 5, taken - base);
    chk("ready while full", 1'b0, in_ready);
    out_rdy <= 1'b1;
    for (int j = 0; j < 8; j++) begin
      take();
      chk("drain order", j, o[29:20]);
    end
    $display("buffer test done");
    complete_run();
  end
endmodule // video_color_dnr_control_test

// [test/video_source.sv]
// upstream pixel source model with valid/ready handshake
module video_source (
  input wire logic ref_clk_i, // clock
  input wire logic resetn_i, // async reset, active low
  input wire logic ready_i, // sink accepts
  output logic valid_o = 1'b0, // pixel offered
  output logic sol_o = 1'b0, // first pixel of line
  output logic sof_o = 1'b0, // first pixel of frame
  output logic [9:0] y_o = 10'h000, // luma
  output logic [9:0] u_o = 10'h000, // U
  output logic [9:0] v_o = 10'h000, // V
  output int taken_o = 0 // pixels accepted
);
  logic [31:0] q[$];
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      valid_o <= 1'b0;
      taken_o <= 0;
    end else begin
      if (valid_o && ready_i)
        taken_o <= taken_o + 1;
      if (!valid_o || ready_i) begin
        if (q.size() != 0) begin
          {sof_o, sol_o, y_o, u_o, v_o} <= q.pop_front();
          valid_o <= 1'b1;
        end else begin
          valid_o <= 1'b0;
          // idle lines toggle so stale data is never mistaken for a pixel
          {y_o, u_o, v_o} <= ~{y_o, u_o, v_o};
        end
      end
    end
  end
endmodule // video_source
